// ### core/shade_stage_defs.svh
`ifndef SHADE_STAGE_DEFS_SVH
`define SHADE_STAGE_DEFS_SVH

// Register byte offsets
`define OFF_STATE_DW0 8'h00
`define OFF_STATE_DW1 8'h04
`define OFF_STATE_DW6 8'h08
`define OFF_GEN_BASE 8'h0c
`define OFF_SKIP_CTRL 8'h10
`define OFF_STATUS 8'h14

// State dword 0 fields
`define KPTR_MSB 31
`define KPTR_LSB 6
`define GRF_MSB 3
`define GRF_LSB 1
// State dword 1 fields
`define SPF_BIT 31
`define BIND_MSB 25
`define BIND_LSB 18
`define PRIO_BIT 17
`define FMODE_BIT 16
`define ILLOP_BIT 13
// State dword 6 fields
`define CDIS_BIT 1
`define SHEN_BIT 0
// Fetch skip control fields
`define INHIBIT_BIT 0
// Position of the illegal-opcode enable in the thread control word
`define CR0_ILLOP_POS 12

// Reset values
`define RST_DW0 32'h0000_0000
`define RST_DW1 32'h0000_0000
`define RST_DW6 32'h0000_0000
`define RST_BASE 32'h0000_0000
`define RST_SKIP 32'h0000_0000

// Registers per register block
`define GRF_BLOCK_REGS 8'h10

`endif

// ### core/shade_stage_pkg.sv
package shade_stage_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_dispatch,
        st_wait_done,
        st_emit
    } flow_state_type;

    typedef enum logic [1:0] {
        mode_pass,
        mode_shade_all,
        mode_cache_pass,
        mode_cache_shade
    } op_mode_type;

endpackage

// ### core/entry_pool.sv
`timescale 1ns/1ps

// Free list of vertex entry handles kept as a bitmap; lowest free goes out.
module entry_pool #(
    parameter int DEPTH = 16,
    parameter int HW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic alloc_valid,
    input wire logic alloc_ready,
    output logic [HW-1:0] alloc_handle,
    input wire logic release_valid,
    input wire logic [HW-1:0] release_handle,
    output logic [HW:0] free_count
);

    initial begin
        if (DEPTH < 1 || DEPTH > 32 || (1 << HW) < DEPTH) begin
            $error("entry_pool: DEPTH must be 1..32 and fit in HW bits");
        end
    end

    logic [DEPTH-1:0] free_q;
    logic [DEPTH-1:0] free_d;
    logic [HW-1:0] low_idx;
    logic found;

    always_comb begin
        low_idx = '0;
        found = 1'b0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (free_q[i]) begin
                low_idx = HW'(i);
                found = 1'b1;
            end
        end
    end

    assign alloc_valid = found;
    assign alloc_handle = low_idx;

    always_comb begin
        free_count = '0;
        for (int i = 0; i < DEPTH; i++) begin
            free_count = free_count + (HW + 1)'(free_q[i]);
        end
    end

    always_comb begin
        free_d = free_q;
        if (found && alloc_ready) begin
            free_d[low_idx] = 1'b0;
        end
        // A returned handle is free again even if taken this same cycle
        if (release_valid && int'(release_handle) < DEPTH) begin
            free_d[release_handle] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            free_q <= '1;
        end else begin
            free_q <= free_d;
        end
    end

endmodule

// ### core/vertex_shade_stage.sv
// Functional notes
// - cache off, shading off: forward references unchanged
// - cache off, shading on: shade every vertex
// - cache on, shading off: forward hits, misses
// - both on: shade misses only, keep order
// - stage supplies entry storage to fetch unit
// - cache-disable bit always disables the cache
// - inhibit bit blocks implicit disable
// - thread fields ignored while shading disabled
// - kernel address is base plus 64-byte offset
// - register blocks are field plus one, 16 each
// - single-flow bit forces one-vertex thread payloads
// - binding count used only for prefetch
// - priority bit selects dispatch priority, program zero
// - float mode bit sets initial float rules
// - illegal-opcode enable copied to control bit 12
// - invalidate on disable, shade toggle, new draw
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "shade_stage_defs.svh"

module vertex_shade_stage #(
    parameter int ENTRIES = 16,
    parameter int HW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Draw command boundary from the fetch unit
    input wire logic draw_start,
    input wire logic draw_sequential,
    // Cache control toward the fetch unit
    output logic cache_enable,
    output logic cache_invalidate,
    // Entry storage handed to the fetch unit
    output logic alloc_valid,
    input wire logic alloc_ready,
    output logic [HW-1:0] alloc_handle,
    input wire logic release_valid,
    input wire logic [HW-1:0] release_handle,
    // Vertex references from the fetch unit
    input wire logic vin_valid,
    output logic vin_ready,
    input wire logic [HW-1:0] vin_handle,
    input wire logic vin_cache_hit,
    // Thread dispatch
    output logic thr_valid,
    input wire logic thr_ready,
    output logic [HW-1:0] thr_handle,
    output logic [31:0] thr_kernel_addr,
    output logic [7:0] thr_grf_regs,
    output logic thr_single_flow,
    output logic [7:0] thr_bind_prefetch,
    output logic thr_high_prio,
    output logic thr_alt_float,
    output logic [15:0] thr_ctrl_word,
    input wire logic thr_done,
    // Vertex references downstream
    output logic vout_valid,
    input wire logic vout_ready,
    output logic [HW-1:0] vout_handle,
    output logic vout_cache_hit
);
    import shade_stage_pkg::*;

    initial begin
        if (HW < 1 || HW > 5 || (1 << HW) < ENTRIES) begin
            $error("vertex_shade_stage: HW must hold ENTRIES handles");
        end
    end

    // Register file
    logic [31:0] dw0_q, dw0_d;
    logic [31:0] dw1_q, dw1_d;
    logic [31:0] dw6_q, dw6_d;
    logic [31:0] base_q, base_d;
    logic [31:0] skip_q, skip_d;
    logic [HW:0] free_count;
    logic wr_en;
    logic rd_hit;

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            `OFF_STATE_DW0, `OFF_STATE_DW1, `OFF_STATE_DW6,
            `OFF_GEN_BASE, `OFF_SKIP_CTRL, `OFF_STATUS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign rd_hit = psel && penable && is_mapped(paddr);
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign wr_en = psel && penable && pwrite && is_mapped(paddr);

    // Flow state
    flow_state_type state_q, state_d;
    logic [HW-1:0] hold_handle_q, hold_handle_d;
    logic hold_hit_q, hold_hit_d;
    logic seq_q, seq_d;
    logic cache_en_q;
    logic shade_en_q;
    logic need_shade;
    logic cache_en_now;
    logic shade_en;
    op_mode_type mode;

    always_comb begin
        dw0_d = dw0_q;
        dw1_d = dw1_q;
        dw6_d = dw6_q;
        base_d = base_q;
        skip_d = skip_q;
        if (wr_en) begin
            case (paddr)
                `OFF_STATE_DW0: dw0_d = pwdata;
                `OFF_STATE_DW1: dw1_d = pwdata;
                `OFF_STATE_DW6: dw6_d = pwdata;
                `OFF_GEN_BASE: base_d = pwdata;
                `OFF_SKIP_CTRL: skip_d = pwdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dw0_q <= `RST_DW0;
            dw1_q <= `RST_DW1;
            dw6_q <= `RST_DW6;
            base_q <= `RST_BASE;
            skip_q <= `RST_SKIP;
        end else begin
            dw0_q <= dw0_d;
            dw1_q <= dw1_d;
            dw6_q <= dw6_d;
            base_q <= base_d;
            skip_q <= skip_d;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_hit && !pwrite) begin
            case (paddr)
                `OFF_STATE_DW0: prdata = dw0_q;
                `OFF_STATE_DW1: prdata = dw1_q;
                `OFF_STATE_DW6: prdata = dw6_q;
                `OFF_GEN_BASE: prdata = base_q;
                `OFF_SKIP_CTRL: prdata = skip_q;
                `OFF_STATUS: prdata = {16'h0000, 3'h0, 5'(free_count),
                    2'h0, mode, cache_en_q, shade_en_q, 2'(state_q)};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // Cache enable and mode selection
    assign shade_en = dw6_q[`SHEN_BIT];
    always_comb begin
        cache_en_now = 1'b1;
        if (dw6_q[`CDIS_BIT]) begin
            cache_en_now = 1'b0;
        end else if (seq_q && !skip_q[`INHIBIT_BIT]) begin
            cache_en_now = 1'b0;
        end
    end

    always_comb begin
        case ({cache_en_now, shade_en})
            2'b00: mode = mode_pass;
            2'b01: mode = mode_shade_all;
            2'b10: mode = mode_cache_pass;
            default: mode = mode_cache_shade;
        endcase
    end

    assign cache_enable = cache_en_now;
    // A draw boundary, a falling cache enable and a shading toggle all flush
    assign cache_invalidate = draw_start
        || (cache_en_q && !cache_en_now)
        || (shade_en_q != shade_en);

    // A hit flag is meaningless once the cache is off, so it is dropped
    always_comb begin
        case (mode)
            mode_pass: need_shade = 1'b0;
            mode_shade_all: need_shade = 1'b1;
            mode_cache_pass: need_shade = 1'b0;
            default: need_shade = !vin_cache_hit;
        endcase
    end

    // One vertex in flight keeps hits and misses in arrival order
    assign vin_ready = (state_q == st_idle);

    always_comb begin
        state_d = state_q;
        hold_handle_d = hold_handle_q;
        hold_hit_d = hold_hit_q;
        seq_d = seq_q;
        if (draw_start) begin
            seq_d = draw_sequential;
        end
        case (state_q)
            st_idle: begin
                if (vin_valid) begin
                    hold_handle_d = vin_handle;
                    hold_hit_d = vin_cache_hit && cache_en_now;
                    state_d = need_shade ? st_dispatch : st_emit;
                end
            end
            st_dispatch: begin
                // Wait for a free thread slot
                if (thr_ready) begin
                    state_d = st_wait_done;
                end
            end
            st_wait_done: begin
                // Thread results overwrite the same entry
                if (thr_done) begin
                    state_d = st_emit;
                end
            end
            st_emit: begin
                if (vout_ready) begin
                    state_d = st_idle;
                end
            end
            default: state_d = st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= st_idle;
            hold_handle_q <= '0;
            hold_hit_q <= 1'b0;
            seq_q <= 1'b0;
            cache_en_q <= 1'b1;
            shade_en_q <= 1'b0;
        end else begin
            state_q <= state_d;
            hold_handle_q <= hold_handle_d;
            hold_hit_q <= hold_hit_d;
            seq_q <= seq_d;
            cache_en_q <= cache_en_now;
            shade_en_q <= shade_en;
        end
    end

    assign thr_valid = (state_q == st_dispatch);
    assign thr_handle = hold_handle_q;
    assign vout_valid = (state_q == st_emit);
    assign vout_handle = hold_handle_q;
    assign vout_cache_hit = hold_hit_q;

    // Thread settings, held at zero while shading is off
    logic [31:0] kaddr_d;
    logic [7:0] grf_d;
    logic [15:0] ctrl_d;
    logic [31:0] kaddr_q;
    logic [7:0] grf_q;
    logic spf_q, prio_q, fmode_q;
    logic [7:0] bind_q;
    logic [15:0] ctrl_q;

    always_comb begin
        kaddr_d = base_q + {dw0_q[`KPTR_MSB:`KPTR_LSB], 6'h00};
        grf_d = 8'({5'h00, dw0_q[`GRF_MSB:`GRF_LSB]} + 8'h01)
            * `GRF_BLOCK_REGS;
        ctrl_d = 16'h0000;
        ctrl_d[`CR0_ILLOP_POS] = dw1_q[`ILLOP_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kaddr_q <= 32'h0000_0000;
            grf_q <= 8'h00;
            spf_q <= 1'b0;
            bind_q <= 8'h00;
            prio_q <= 1'b0;
            fmode_q <= 1'b0;
            ctrl_q <= 16'h0000;
        end else begin
            kaddr_q <= shade_en ? kaddr_d : 32'h0000_0000;
            grf_q <= shade_en ? grf_d : 8'h00;
            spf_q <= shade_en && dw1_q[`SPF_BIT];
            bind_q <= shade_en ? dw1_q[`BIND_MSB:`BIND_LSB] : 8'h00;
            prio_q <= shade_en && dw1_q[`PRIO_BIT];
            fmode_q <= shade_en && dw1_q[`FMODE_BIT];
            ctrl_q <= shade_en ? ctrl_d : 16'h0000;
        end
    end

    assign thr_kernel_addr = kaddr_q;
    assign thr_grf_regs = grf_q;
    // Always one vertex per payload, legal in either flow mode
    assign thr_single_flow = spf_q;
    assign thr_bind_prefetch = bind_q;
    assign thr_high_prio = prio_q;
    assign thr_alt_float = fmode_q;
    assign thr_ctrl_word = ctrl_q;

    // Entry storage for the fetch unit; empty pool stalls it
    entry_pool #(
        .DEPTH(ENTRIES),
        .HW(HW)
    ) u_pool (
        .pclk(pclk),
        .presetn(presetn),
        .alloc_valid(alloc_valid),
        .alloc_ready(alloc_ready),
        .alloc_handle(alloc_handle),
        .release_valid(release_valid),
        .release_handle(release_handle),
        .free_count(free_count)
    );

endmodule

// ### sim/vs_checker_properties.sv
`timescale 1ns/1ps
module vs_checker #(
    parameter int HW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic draw_start,
    input wire logic cache_enable,
    input wire logic cache_invalidate,
    input wire logic alloc_valid,
    input wire logic alloc_ready,
    input wire logic [HW-1:0] alloc_handle,
    input wire logic release_valid,
    input wire logic vin_valid,
    input wire logic vin_ready,
    input wire logic [HW-1:0] vin_handle,
    input wire logic vin_cache_hit,
    input wire logic thr_valid,
    input wire logic thr_ready,
    input wire logic [HW-1:0] thr_handle,
    input wire logic [7:0] thr_grf_regs,
    input wire logic vout_valid,
    input wire logic vout_ready,
    input wire logic [HW-1:0] vout_handle
);
    // Last accepted handle; one vertex is in flight at a time
    logic [HW-1:0] last_in_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_in_q <= '0;
        end else if (vin_valid && vin_ready) begin
            last_in_q <= vin_handle;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    vin_stall_a: assert property (
        (thr_valid || vout_valid) |-> !vin_ready)
        else $error("input accepted while a vertex is pending");
    thr_hold_a: assert property (
        thr_valid && !thr_ready |=> thr_valid && $stable(thr_handle))
        else $error("thread request dropped before ready");
    vout_hold_a: assert property (
        vout_valid && !vout_ready |=> vout_valid && $stable(vout_handle))
        else $error("output reference dropped before ready");
    hit_bypass_a: assert property (
        vin_valid && vin_ready && vin_cache_hit && cache_enable
        |=> vout_valid && !thr_valid)
        else $error("cache hit was not passed straight on");
    out_order_a: assert property (
        vout_valid |-> vout_handle == last_in_q)
        else $error("output handle differs from accepted handle");
    grf_range_a: assert property (
        thr_grf_regs != 8'h00 |-> thr_grf_regs[3:0] == 4'h0
        && thr_grf_regs <= 8'h80)
        else $error("register count out of range");
    draw_inval_a: assert property (
        draw_start |-> cache_invalidate)
        else $error("no invalidate at draw start");
    off_inval_a: assert property (
        $fell(cache_enable) |-> cache_invalidate)
        else $error("no invalidate when cache turned off");
    alloc_next_a: assert property (
        alloc_valid && alloc_ready && !release_valid
        |=> alloc_handle != $past(alloc_handle))
        else $error("taken entry handed out again");
    thr_cov: cover property (thr_valid && thr_ready);
    hit_cov: cover property (vin_valid && vin_ready && vin_cache_hit);
    stall_cov: cover property (vout_valid && !vout_ready);
endmodule

bind vertex_shade_stage vs_checker #(.HW(HW)) u_chk (.*);

// ### sim/thread_unit_model.sv
`timescale 1ns/1ps
// Dispatcher stand-in: takes one thread, finishes it lat plus two cycles after its ready pulse
module thread_unit_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic thr_valid,
    input wire logic [3:0] lat,
    output logic thr_ready,
    output logic thr_done
);
    logic busy;
    logic [3:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_ready <= 1'b0;
            thr_done <= 1'b0;
            busy <= 1'b0;
            cnt <= 4'h0;
        end else begin
            thr_ready <= 1'b0;
            thr_done <= 1'b0;
            if (thr_valid && !thr_ready && !busy) begin
                thr_ready <= 1'b1;
                busy <= 1'b1;
                cnt <= lat;
            end else if (busy && !thr_ready) begin
                if (cnt == 4'h0) begin
                    thr_done <= 1'b1;
                    busy <= 1'b0;
                end else begin
                    cnt <= cnt - 4'h1;
                end
            end
        end
    end
endmodule

// ### sim/vertex_shade_stage_tb.sv
`timescale 1ns/1ps
`include "shade_stage_defs.svh"
module vertex_shade_stage_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, thr_grf_regs, thr_bind_prefetch;
    logic [31:0] pwdata = 32'h0, prdata, thr_kernel_addr, rd, d0, d1;
    logic pready, pslverr, cache_enable, cache_invalidate, err;
    logic draw_start = 0, draw_sequential = 0, alloc_valid;
    logic alloc_ready = 0, release_valid = 0, vin_valid = 0;
    logic [3:0] alloc_handle, release_handle = 4'h0, vin_handle = 4'h0;
    logic [3:0] thr_handle, vout_handle, lat = 4'h0;
    logic vin_ready, vin_cache_hit = 0, thr_valid, thr_ready, thr_done;
    logic thr_single_flow, thr_high_prio, thr_alt_float;
    logic [15:0] thr_ctrl_word;
    logic vout_valid, vout_ready = 1, vout_cache_hit;
    int errors = 0, comparisons = 0;
    vertex_shade_stage dut (.*);
    thread_unit_model partner (.*);
    always #25 pclk = ~pclk;
    task automatic chk(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic draw(input logic s);
        @(posedge pclk);
        draw_start <= 1; draw_sequential <= s;
        @(negedge pclk);
        chk("cache_invalidate", 1, cache_invalidate);
        @(posedge pclk);
        draw_start <= 0;
        @(negedge pclk);
    endtask
    // Sends one vertex and judges its way through the stage
    task automatic vtx(input logic [3:0] h, input logic hit, thr, hexp);
        logic saw;
        saw = 0;
        @(posedge pclk);
        vin_valid <= 1; vin_handle <= h; vin_cache_hit <= hit;
        do @(posedge pclk); while (vin_ready !== 1'b1);
        vin_valid <= 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge pclk);
            if (thr_valid === 1'b1) begin
                saw = 1;
                chk("thr_handle", h, thr_handle);
            end
            if (vout_valid === 1'b1 && vout_ready === 1'b1) break;
        end
        chk("vout_valid", 1, vout_valid);
        chk("vout_handle", h, vout_handle);
        chk("vout_cache_hit", hexp, vout_cache_hit);
        chk("thread spawned", thr, saw);
    endtask
    task automatic t_regs();
        logic [7:0] offs [5];
        offs = '{`OFF_STATE_DW0, `OFF_STATE_DW1, `OFF_STATE_DW6,
            `OFF_GEN_BASE, `OFF_SKIP_CTRL};
        foreach (offs[i]) begin
            apb(0, offs[i], 0);
            chk("reset value", 0, rd);
            chk("pslverr", 0, err);
        end
        apb(1, 8'h40, 32'hffff_ffff);
        chk("pslverr", 1, err);
        apb(0, 8'h40, 0);
        chk("unmapped read", 0, rd);
        chk("cache_enable", 1, cache_enable);
        chk("pready", 1, pready);
        // Idle, cache pass mode, cache enabled last cycle, all entries free
        apb(0, `OFF_STATUS, 0);
        chk("status", 32'h0000_1028, rd);
        $display("test regs done");
    endtask
    task automatic t_pool();
        chk("alloc_valid", 1, alloc_valid);
        chk("alloc_handle", 0, alloc_handle);
        @(posedge pclk) alloc_ready <= 1;
        @(posedge pclk) alloc_ready <= 0;
        @(negedge pclk) chk("alloc_handle", 1, alloc_handle);
        @(posedge pclk) begin
            release_valid <= 1; release_handle <= 0;
        end
        @(posedge pclk) release_valid <= 0;
        @(negedge pclk) chk("alloc_handle", 0, alloc_handle);
        $display("test pool done");
    endtask
    task automatic t_modes();
        apb(1, `OFF_STATE_DW6, 0);
        draw(0);
        vtx(1, 1, 0, 1);
        vtx(2, 0, 0, 0);
        apb(1, `OFF_STATE_DW6, 1);
        draw(0);
        vtx(3, 1, 0, 1);
        lat <= 4'h8;
        vtx(4, 0, 1, 0);
        apb(1, `OFF_STATE_DW6, 3);
        // The write lands at the edge the task returns on
        @(negedge pclk);
        chk("cache_enable", 0, cache_enable);
        vtx(5, 1, 1, 0);
        apb(1, `OFF_STATE_DW6, 2);
        vtx(6, 1, 0, 0);
        $display("test modes done");
    endtask
    task automatic t_thread();
        // Base keeps the kernel below 4G; reserved bits left zero
        apb(1, `OFF_GEN_BASE, 32'h1000_0010);
        for (int i = 0; i < 2; i++) begin
            d0 = i ? 32'h0000_0040 : 32'h0000_0a4e;
            d1 = i ? 32'h0 : 32'h8005_2000;
            apb(1, `OFF_STATE_DW0, d0);
            apb(1, `OFF_STATE_DW1, d1);
            apb(1, `OFF_STATE_DW6, 1);
            // Thread settings register one cycle after the enable lands
            @(posedge pclk);
            @(negedge pclk);
            chk("kernel", 32'h1000_0010 + (d0 & 32'hffff_ffc0),
                thr_kernel_addr);
            chk("grf", i ? 8'h10 : 8'h80, thr_grf_regs);
            chk("single", !i, thr_single_flow);
            chk("bind", i ? 0 : 1, thr_bind_prefetch);
            chk("prio", 0, thr_high_prio);
            chk("float", !i, thr_alt_float);
            chk("ctrl", i ? 0 : 16'h1000, thr_ctrl_word);
        end
        apb(1, `OFF_STATE_DW0, 32'h0000_0a4e);
        apb(1, `OFF_STATE_DW6, 0);
        @(posedge pclk);
        @(negedge pclk);
        chk("kernel off", 0, thr_kernel_addr);
        chk("grf off", 0, thr_grf_regs);
        $display("test thread done");
    endtask
    task automatic t_cache();
        draw(1);
        chk("cache_enable", 0, cache_enable);
        apb(1, `OFF_SKIP_CTRL, 1);
        draw(1);
        chk("cache_enable", 1, cache_enable);
        @(posedge pclk) vout_ready <= 0;
        vtx_hold();
        @(posedge pclk) vout_ready <= 1;
        repeat (2) @(posedge pclk);
        @(negedge pclk) chk("vin_ready", 1, vin_ready);
        $display("test cache done");
    endtask
    task automatic vtx_hold();
        @(posedge pclk);
        vin_valid <= 1; vin_handle <= 4'h9;
        do @(posedge pclk); while (vin_ready !== 1'b1);
        vin_valid <= 0;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk("vin_ready", 0, vin_ready);
        chk("vout_handle", 4'h9, vout_handle);
    endtask
    initial begin
        #100us;
        errors++;
        results();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_regs();
        t_pool();
        t_modes();
        t_thread();
        t_cache();
        results();
    end
endmodule
